/* File: cptd_params.svh */
// Register indices, field positions, reset values and timing counts for the tone detector
`ifndef CPTD_PARAMS_SVH
`define CPTD_PARAMS_SVH

// Register indices on the serial control port
`define CPTD_IDX_CONTROL 3'h0
`define CPTD_IDX_MIN_TIMES 3'h1
`define CPTD_IDX_MAX_TIMES 3'h2
`define CPTD_IDX_DIFF_LIMITS 3'h3
`define CPTD_IDX_CYCLE_THR 3'h4
`define CPTD_IDX_STATUS 3'h5

// Control fields
`define CPTD_CTL_EN_BIT 0
`define CPTD_CTL_MODE_BIT 1
`define CPTD_CTL_SRC_LSB 2
`define CPTD_CTL_SRC_MSB 6
// Paired 8-bit fields: burst in the low byte, gap in the high byte
`define CPTD_BURST_LSB 0
`define CPTD_BURST_MSB 7
`define CPTD_GAP_LSB 8
`define CPTD_GAP_MSB 15
// Cycle count and thresholds
`define CPTD_NUM_LSB 0
`define CPTD_NUM_MSB 2
`define CPTD_LEVEL_LSB 3
`define CPTD_LEVEL_MSB 10
`define CPTD_SNR_LSB 11
`define CPTD_SNR_MSB 14

// Write masks and reset values
`define CPTD_CONTROL_MASK 16'h007F
`define CPTD_CYCLE_THR_MASK 16'h7FFF
`define CPTD_REG_RESET 16'h0000

// Timing: clock period and tick period in ns
`define CPTD_CLK_PERIOD_NS 8
`define CPTD_TICK_PERIOD_NS 1000000
`define CPTD_MIN_CYCLES 3'h2
`define CPTD_LEN_MAX 8'hFF
`define CPTD_CYC_MAX 3'h7

`endif

/* File: cptd_pkg.sv */
// Types shared by the call progress tone detector
package cptd_pkg;
  typedef enum logic {
    CPTD_MODE_COOKED,
    CPTD_MODE_RAW
  } cptd_mode_t;

  typedef enum logic [1:0] {
    CPTD_ST_QUIET,
    CPTD_ST_ARMED,
    CPTD_ST_BURST,
    CPTD_ST_GAP
  } cptd_state_t;
endpackage : cptd_pkg

/* File: cptd_timing_checker.sv */
// Burst/gap timing checker for cooked mode
`timescale 1ns/100ps
`include "cptd_params.svh"
module cptd_timing_checker import cptd_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic chk_rst,
  // Measurement
  input wire logic tick,
  input wire logic present,
  // Limits
  input wire logic [7:0] burst_time_floor,
  input wire logic [7:0] burst_time_ceiling,
  input wire logic [7:0] gap_time_floor,
  input wire logic [7:0] gap_time_ceiling,
  input wire logic [7:0] burst_spread_limit,
  input wire logic [7:0] gap_spread_limit,
  input wire logic [2:0] cycle_count,
  // Result
  output logic qualified
);

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction : abs_diff

  cptd_state_t state_q, state_d;
  logic [7:0] len_q, len_d;
  logic [7:0] prev_b_q, prev_b_d;
  logic [7:0] prev_g_q, prev_g_d;
  logic have_b_q, have_b_d;
  logic have_g_q, have_g_d;
  logic [2:0] cyc_q, cyc_d;
  logic qual_q, qual_d;
  logic [2:0] need;
  logic [7:0] len_inc;
  logic burst_ok;
  logic gap_ok;

  assign qualified = qual_q;

  always_comb begin
    // Fewer than two cycles never qualifies, whatever is programmed
    need = (cycle_count < `CPTD_MIN_CYCLES) ? `CPTD_MIN_CYCLES : cycle_count;
    len_inc = (len_q == `CPTD_LEN_MAX) ? len_q : len_q + 8'h01;
    burst_ok = (len_q >= burst_time_floor) && (len_q <= burst_time_ceiling) &&
               (!have_b_q || abs_diff(len_q, prev_b_q) <= burst_spread_limit);
    gap_ok = (len_q >= gap_time_floor) && (len_q <= gap_time_ceiling) &&
             (!have_g_q || abs_diff(len_q, prev_g_q) <= gap_spread_limit);
    state_d = state_q;
    len_d = len_q;
    prev_b_d = prev_b_q;
    prev_g_d = prev_g_q;
    have_b_d = have_b_q;
    have_g_d = have_g_q;
    cyc_d = cyc_q;
    qual_d = 1'b0;
    if (tick) begin
      unique case (state_q)
        CPTD_ST_QUIET: begin
          // A burst already running when we restart has an unknown length
          if (!present) begin
            state_d = CPTD_ST_ARMED;
          end
        end
        CPTD_ST_ARMED: begin
          if (present) begin
            state_d = CPTD_ST_BURST;
            len_d = 8'h01;
          end
        end
        CPTD_ST_BURST: begin
          if (present) begin
            len_d = len_inc;
            if (len_q > burst_time_ceiling) begin
              state_d = CPTD_ST_QUIET;
              have_b_d = 1'b0;
              have_g_d = 1'b0;
              cyc_d = 3'h0;
            end
          end else if (burst_ok) begin
            prev_b_d = len_q;
            have_b_d = 1'b1;
            state_d = CPTD_ST_GAP;
            len_d = 8'h01;
          end else begin
            state_d = CPTD_ST_ARMED;
            have_b_d = 1'b0;
            have_g_d = 1'b0;
            cyc_d = 3'h0;
          end
        end
        CPTD_ST_GAP: begin
          if (!present) begin
            len_d = len_inc;
            if (len_q > gap_time_ceiling) begin
              state_d = CPTD_ST_ARMED;
              have_b_d = 1'b0;
              have_g_d = 1'b0;
              cyc_d = 3'h0;
            end
          end else if (gap_ok) begin
            // Burst plus gap completes one cycle; the burst now starting sets the flag once the count reaches need
            prev_g_d = len_q;
            have_g_d = 1'b1;
            cyc_d = (cyc_q == `CPTD_CYC_MAX) ? cyc_q : cyc_q + 3'h1;
            qual_d = ((cyc_q + 3'h1) >= need) || (cyc_q == `CPTD_CYC_MAX);
            state_d = CPTD_ST_BURST;
            len_d = 8'h01;
          end else begin
            // The burst starting now is the next candidate
            state_d = CPTD_ST_BURST;
            len_d = 8'h01;
            have_b_d = 1'b0;
            have_g_d = 1'b0;
            cyc_d = 3'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (chk_rst) begin
      state_q <= CPTD_ST_QUIET;
      len_q <= 8'h00;
      prev_b_q <= 8'h00;
      prev_g_q <= 8'h00;
      have_b_q <= 1'b0;
      have_g_q <= 1'b0;
      cyc_q <= 3'h0;
      qual_q <= 1'b0;
    end else begin
      state_q <= state_d;
      len_q <= len_d;
      prev_b_q <= prev_b_d;
      prev_g_q <= prev_g_d;
      have_b_q <= have_b_d;
      have_g_q <= have_g_d;
      cyc_q <= cyc_d;
      qual_q <= qual_d;
    end
  end

endmodule : cptd_timing_checker

/* File: cptd_detector.sv */
// Call progress tone detector: registers, signal presence, tick and flag
//
// What this block does
// - The selected input is watched while the unit is enabled and the flag reports a tone in the 340-640 Hz band.
// - Raw mode reports a qualifying signal straight away without the timing checker.
// - In cooked mode a burst followed by a gap is one cycle and at least two cycles are needed.
// - In cooked mode the flag is set on the first burst after the programmed cycle count is seen.
// - Once set in cooked mode the flag stays on until the unit is disabled or switched to raw mode.
// - Bursts and gaps are accepted only between their 8-bit minimum and maximum times.
// - Consecutive bursts and consecutive gaps may differ by at most their 8-bit spread limits.
// - Any timing violation resets the checker, which restarts with the next valid burst.
// - Reading status leaves the flag alone, and disabling the unit clears it.
// - A signal counts as present only at or above the 8-bit level and 4-bit SNR floors.
// - There is a unit enable, a raw/cooked select and a 5-bit input source select.
`timescale 1ns/100ps
`include "cptd_params.svh"
module cptd_detector import cptd_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `CPTD_TICK_PERIOD_NS / `CPTD_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial control port register access
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [2:0] reg_index,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Band-pass stage results for the selected source
  input wire logic [7:0] band_level,
  input wire logic [3:0] band_snr,
  // Source routing and result
  output logic [4:0] input_source_select,
  output logic call_progress_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] tone_detect_control_q, tone_detect_control_d;
  logic [15:0] tone_minimum_times_q, tone_minimum_times_d;
  logic [15:0] tone_maximum_times_q, tone_maximum_times_d;
  logic [15:0] tone_difference_limits_q, tone_difference_limits_d;
  logic [15:0] tone_cycle_and_thresholds_q, tone_cycle_and_thresholds_d;
  logic [15:0] rdata_q, rdata_d;
  logic unit_en;
  cptd_mode_t mode;

  assign unit_en = tone_detect_control_q[`CPTD_CTL_EN_BIT];
  assign mode = cptd_mode_t'(tone_detect_control_q[`CPTD_CTL_MODE_BIT]);
  assign input_source_select = tone_detect_control_q[`CPTD_CTL_SRC_MSB:`CPTD_CTL_SRC_LSB];
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  // Bits above a register's width are dropped on write, so they always read back as zero
  function automatic logic [15:0] write_mask(input logic [2:0] idx);
    unique case (idx)
      `CPTD_IDX_CONTROL: write_mask = `CPTD_CONTROL_MASK;
      `CPTD_IDX_CYCLE_THR: write_mask = `CPTD_CYCLE_THR_MASK;
      `CPTD_IDX_MIN_TIMES, `CPTD_IDX_MAX_TIMES, `CPTD_IDX_DIFF_LIMITS: write_mask = 16'hFFFF;
      // Status and unused indices take no write
      default: write_mask = 16'h0000;
    endcase
  endfunction : write_mask

  logic [15:0] wr_word;
  assign wr_word = reg_wdata & write_mask(reg_index);

  always_comb begin
    tone_detect_control_d = tone_detect_control_q;
    tone_minimum_times_d = tone_minimum_times_q;
    tone_maximum_times_d = tone_maximum_times_q;
    tone_difference_limits_d = tone_difference_limits_q;
    tone_cycle_and_thresholds_d = tone_cycle_and_thresholds_q;
    if (reg_wr_en) begin
      unique case (reg_index)
        `CPTD_IDX_CONTROL: tone_detect_control_d = wr_word;
        `CPTD_IDX_MIN_TIMES: tone_minimum_times_d = wr_word;
        `CPTD_IDX_MAX_TIMES: tone_maximum_times_d = wr_word;
        `CPTD_IDX_DIFF_LIMITS: tone_difference_limits_d = wr_word;
        `CPTD_IDX_CYCLE_THR: tone_cycle_and_thresholds_d = wr_word;
        default: ;
      endcase
    end
    // Status is read-only and a read has no side effect on the flag
    rdata_d = rdata_q;
    if (reg_rd_en) begin
      unique case (reg_index)
        `CPTD_IDX_CONTROL: rdata_d = tone_detect_control_q;
        `CPTD_IDX_MIN_TIMES: rdata_d = tone_minimum_times_q;
        `CPTD_IDX_MAX_TIMES: rdata_d = tone_maximum_times_q;
        `CPTD_IDX_DIFF_LIMITS: rdata_d = tone_difference_limits_q;
        `CPTD_IDX_CYCLE_THR: rdata_d = tone_cycle_and_thresholds_q;
        `CPTD_IDX_STATUS: rdata_d = {15'h0000, call_progress_flag};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tone_detect_control_q <= `CPTD_REG_RESET;
      tone_minimum_times_q <= `CPTD_REG_RESET;
      tone_maximum_times_q <= `CPTD_REG_RESET;
      tone_difference_limits_q <= `CPTD_REG_RESET;
      tone_cycle_and_thresholds_q <= `CPTD_REG_RESET;
      rdata_q <= 16'h0000;
    end else begin
      tone_detect_control_q <= tone_detect_control_d;
      tone_minimum_times_q <= tone_minimum_times_d;
      tone_maximum_times_q <= tone_maximum_times_d;
      tone_difference_limits_q <= tone_difference_limits_d;
      tone_cycle_and_thresholds_q <= tone_cycle_and_thresholds_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register fields
  // Burst limits sit in the low byte of each pair, gap limits in the high byte
  logic [7:0] burst_time_floor;
  logic [7:0] gap_time_floor;
  logic [7:0] burst_time_ceiling;
  logic [7:0] gap_time_ceiling;
  logic [7:0] burst_spread_limit;
  logic [7:0] gap_spread_limit;
  logic [2:0] cycle_count;
  // Presence thresholds
  logic [7:0] level_floor;
  logic [3:0] snr_floor;

  assign burst_time_floor = tone_minimum_times_q[`CPTD_BURST_MSB:`CPTD_BURST_LSB];
  assign gap_time_floor = tone_minimum_times_q[`CPTD_GAP_MSB:`CPTD_GAP_LSB];
  assign burst_time_ceiling = tone_maximum_times_q[`CPTD_BURST_MSB:`CPTD_BURST_LSB];
  assign gap_time_ceiling = tone_maximum_times_q[`CPTD_GAP_MSB:`CPTD_GAP_LSB];
  assign burst_spread_limit = tone_difference_limits_q[`CPTD_BURST_MSB:`CPTD_BURST_LSB];
  assign gap_spread_limit = tone_difference_limits_q[`CPTD_GAP_MSB:`CPTD_GAP_LSB];
  assign cycle_count = tone_cycle_and_thresholds_q[`CPTD_NUM_MSB:`CPTD_NUM_LSB];
  assign level_floor = tone_cycle_and_thresholds_q[`CPTD_LEVEL_MSB:`CPTD_LEVEL_LSB];
  assign snr_floor = tone_cycle_and_thresholds_q[`CPTD_SNR_MSB:`CPTD_SNR_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Presence and tick
  logic present_q, present_d;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    // Presence is registered once so both modes judge the same sample
    present_d = unit_en &&
      (band_level >= level_floor) &&
      (band_snr >= snr_floor);
    // Tick restarts on enable so the first interval is a full one
    // The count is wide enough for the default one-millisecond tick
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h1;
    if (!unit_en) begin
      tick_cnt_d = 32'h0;
    end else if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 32'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      present_q <= 1'b0;
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      present_q <= present_d;
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing checker and flag
  logic qualified;
  logic chk_rst;
  logic flag_q, flag_d;

  // Checker is held in reset while disabled or in raw mode
  assign chk_rst = sys_rst || !unit_en || (mode == CPTD_MODE_RAW);
  assign call_progress_flag = flag_q;

  // Limits are read live, so reprogramming them mid-run takes effect at the next tick
  cptd_timing_checker u_checker (
    .mclk(mclk),
    .chk_rst(chk_rst),
    .tick(tick_q),
    .present(present_q),
    .burst_time_floor(burst_time_floor),
    .burst_time_ceiling(burst_time_ceiling),
    .gap_time_floor(gap_time_floor),
    .gap_time_ceiling(gap_time_ceiling),
    .burst_spread_limit(burst_spread_limit),
    .gap_spread_limit(gap_spread_limit),
    .cycle_count(cycle_count),
    .qualified(qualified)
  );

  always_comb begin
    // Raw mode has no memory: the flag follows presence cycle by cycle
    flag_d = flag_q;
    if (!unit_en) begin
      flag_d = 1'b0;
    end else if (mode == CPTD_MODE_RAW) begin
      flag_d = present_q;
    end else if (qualified) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : cptd_detector

/* File: cptd_detector_props.sv */
// Port assertions for the tone detector, bound to its top
`timescale 1ns/100ps
module cptd_detector_props #(
  parameter int unsigned TICK_CYCLES = 125000
) (
  // Clock, reset and register port
  input logic mclk,
  input logic sys_rst,
  input logic reg_wr_en,
  input logic reg_rd_en,
  input logic [2:0] reg_index,
  input logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  // Band stage and results
  input logic [7:0] band_level,
  input logic [3:0] band_snr,
  input logic [4:0] input_source_select,
  input logic call_progress_flag
);
  // Shadow registers and the registered presence the detector should hold
  logic [6:0] ctl_q, ctl_d;
  logic [14:0] thr_q, thr_d;
  logic pres_q, pres_d;
  logic [19:0] cnt_q, cnt_d;
  always_comb begin
    ctl_d = ctl_q;
    thr_d = thr_q;
    if (reg_wr_en && reg_index == 3'h0) ctl_d = reg_wdata[6:0];
    if (reg_wr_en && reg_index == 3'h4) thr_d = reg_wdata[14:0];
    pres_d = ctl_q[0] && band_level >= thr_q[10:3] && band_snr >= thr_q[14:11];
    cnt_d = (ctl_q[1:0] != 2'b01) ? 20'h0 : cnt_q + {19'h0, ~&cnt_q};
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {ctl_q, thr_q, pres_q, cnt_q} <= '0;
    end else begin
      {ctl_q, thr_q, pres_q, cnt_q} <= {ctl_d, thr_d, pres_d, cnt_d};
    end
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  a_source_follows: assert property (input_source_select == ctl_q[6:2])
    else $error("source select differs");
  a_control_read: assert property (
    reg_rd_en && reg_index == 3'h0 |=> reg_rdata == {9'h0, $past(ctl_q)})
    else $error("control read wrong");
  a_status_read: assert property (
    reg_rd_en && reg_index == 3'h5 |=> reg_rdata == {15'h0, $past(call_progress_flag)})
    else $error("status read wrong");
  a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved");
  a_off_clears: assert property (!ctl_q[0] |=> !call_progress_flag)
    else $error("flag set while disabled");
  a_raw_follows: assert property (
    ctl_q[1:0] == 2'b11 |=> call_progress_flag == $past(pres_q))
    else $error("raw flag wrong");
  a_cooked_sticky: assert property (
    ctl_q[1:0] == 2'b01 && call_progress_flag |=> call_progress_flag)
    else $error("cooked flag dropped");
  a_flag_on_burst: assert property (
    $rose(call_progress_flag) && ctl_q[1:0] == 2'b01 |-> $past(pres_q, 2))
    else $error("flag rose outside a burst");
  // Quiet tick, arming to the first burst start and two full cycles span six tick periods, more than the five checked
  a_cooked_dwell: assert property (
    $rose(call_progress_flag) && ctl_q[1:0] == 2'b01 |-> cnt_q >= 5 * TICK_CYCLES)
    else $error("flag rose too early");
endmodule : cptd_detector_props
bind cptd_detector cptd_detector_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.mclk(mclk),
  .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_index(reg_index),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .band_level(band_level), .band_snr(band_snr),
  .input_source_select(input_source_select), .call_progress_flag(call_progress_flag));

/* File: cptd_ctrl_bfm.sv */
// Controller model driving the serial control port
`timescale 1ns/100ps
module cptd_ctrl_bfm (
  // Clock and answer
  input wire logic mclk,
  input wire logic [15:0] reg_rdata,
  // Requests
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [2:0] reg_index,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_index = 3'h7;
    reg_wdata = 16'h0000;
  end
  // Released lines show inverted values so stale bits are never trusted
  task automatic wr(input logic [2:0] i, input logic [15:0] v);
    @(posedge mclk);
    reg_wr_en <= 1'b1;
    reg_index <= i;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
    reg_index <= ~i;
    reg_wdata <= ~v;
  endtask : wr
  task automatic rd(input logic [2:0] i, output logic [15:0] v);
    @(posedge mclk);
    reg_rd_en <= 1'b1;
    reg_index <= i;
    @(posedge mclk);
    reg_rd_en <= 1'b0;
    reg_index <= ~i;
    #1 v = reg_rdata;
  endtask : rd
endmodule : cptd_ctrl_bfm

/* File: tb_top.sv */
// Self-checking bench for the tone detector
`timescale 1ns/100ps
module tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] band_level = 8'h00;
  logic [3:0] band_snr = 4'h0;
  logic reg_wr_en, reg_rd_en, call_progress_flag;
  logic [2:0] reg_index;
  logic [4:0] input_source_select;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [15:0] rnd = 16'hBF6E;
  int failures = 0, n_checks = 0, cyc = 0;
  int pat[$], q[$];
  initial forever #4 mclk = ~mclk;
  cptd_ctrl_bfm ctl (.mclk(mclk), .reg_rdata(reg_rdata), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_index(reg_index), .reg_wdata(reg_wdata));
  cptd_detector #(.TICK_CYCLES(4)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_index(reg_index),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .band_level(band_level),
    .band_snr(band_snr), .input_source_select(input_source_select),
    .call_progress_flag(call_progress_flag));
  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input logic [15:0] got, input logic [15:0] want, input string m);
    n_checks++;
    if (got !== want) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  // Timing model over pat: limits 2..6 ticks, spread 1; bad burst also drops its gap
  function automatic logic model(input int need);
    int cy = 0;
    int pv[2] = '{-1, -1};
    int k;
    if (need < 2) need = 2;
    for (int i = 0; i < pat.size(); i++) begin
      k = i % 2;
      if (k == 0 && cy >= need) return 1'b1;
      if (pat[i] < 2 || pat[i] > 6 || (pv[k] >= 0 && (pat[i] > pv[k] + 1 || pv[k] > pat[i] + 1)))
      begin
        cy = 0;
        pv = '{-1, -1};
        i += 1 - k;
      end else begin
        pv[k] = pat[i];
        cy += k;
      end
    end
    return 1'b0;
  endfunction : model
  // Off level sits one step under the level floor, on exactly at both floors
  task automatic hold(input int t, input bit on);
    @(posedge mclk);
    band_level <= on ? 8'h40 : 8'h3F;
    band_snr <= on ? 4'h8 : 4'hF;
    repeat (t * 4 - 1) @(posedge mclk);
    #1;
  endtask : hold
  task automatic run_cooked(input int need);
    logic e;
    e = model(need);
    rnd = lfsr(rnd);
    ctl.wr(3'h4, {1'b0, 4'h8, 8'h40, need[2:0]});
    ctl.wr(3'h0, {9'h000, rnd[4:0], 2'b01});
    hold(2, 1'b0);
    foreach (pat[i]) hold(pat[i], i % 2 == 0);
    hold(2, 1'b0);
    check(call_progress_flag, e, "cooked flag");
    hold(20, 1'b0);
    check(call_progress_flag, e, "flag not held");
    ctl.rd(3'h5, d);
    check(d, {15'h0000, e}, "status word");
    check(call_progress_flag, e, "flag moved on read");
    ctl.wr(3'h0, 16'h0000);
    @(posedge mclk);
    #1 check(call_progress_flag, 1'b0, "flag not cleared");
    $display("test cooked %0d done", need);
  endtask : run_cooked
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      ctl.rd(i[2:0], d);
      check(d, 16'h0000, "reset value");
    end
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      ctl.wr(i[2:0], rnd);
      ctl.rd(i[2:0], d);
      check(d, rnd & (i == 0 ? 16'h007F : i == 4 ? 16'h7FFF : 16'hFFFF), "readback");
      if (i == 0) check(input_source_select, rnd[6:2], "source select");
    end
    ctl.wr(3'h0, 16'h0000);
    ctl.wr(3'h5, 16'hFFFF);
    ctl.rd(3'h5, d);
    check(d, 16'h0000, "status write");
    $display("test registers done");
    // Limits the timing model assumes: 2..6 ticks, spread 1
    ctl.wr(3'h1, 16'h0202);
    ctl.wr(3'h2, 16'h0606);
    ctl.wr(3'h3, 16'h0101);
    pat = '{4, 4, 4, 4, 4};
    run_cooked(2);
    pat = '{4, 4, 5, 4, 4};
    run_cooked(2);
    pat = '{4, 4, 6, 4, 4};
    run_cooked(2);
    pat = '{4, 3, 4, 6, 4};
    run_cooked(2);
    pat = '{8, 4, 4, 4, 4};
    run_cooked(2);
    pat = '{1, 4, 4, 4, 4, 4, 4};
    run_cooked(2);
    pat = '{4, 4, 4};
    run_cooked(1);
    pat = '{4, 4, 4, 4, 4};
    run_cooked(3);
    repeat (3) begin
      pat.delete();
      repeat (7) begin
        rnd = lfsr(rnd);
        pat.push_back(2 + rnd % 3);
      end
      run_cooked(2);
    end
    ctl.wr(3'h4, {1'b0, 4'h8, 8'h80, 3'h0});
    ctl.wr(3'h0, 16'h0003);
    repeat (60) begin
      @(posedge mclk);
      rnd = lfsr(rnd);
      band_level <= rnd[7:0];
      band_snr <= rnd[11:8];
      q.push_back(rnd[7:0] >= 8'h80 && rnd[11:8] >= 4'h8);
      @(negedge mclk);
      if (q.size() > 2) check(call_progress_flag, q.pop_front(), "raw flag");
    end
    $display("test raw done");
    tally_and_finish();
  end
endmodule : tb_top
